// ### hdl/dsos_pkg.sv
// Purpose: Shared constants for drive status output select
// Assumes: 32-bit Avalon-MM registers, byte addresses, frequency in 0.01 Hz units
// Notes:   Current in 0.1 A units, thermal level in percent
package dsos_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          FREQ_W         = 16;
  localparam int          CODE_W         = 4;
  localparam int          NUM_DIN        = 6;
  localparam int          NUM_STAGE      = 16;
  localparam int          NUM_IRQ        = 5;
  // Register byte offsets
  localparam logic [7:0]  OFF_DIN_SEL    = 8'h00;
  localparam logic [7:0]  OFF_RELAY_SEL  = 8'h18;
  localparam logic [7:0]  OFF_DOUT_SEL   = 8'h1C;
  localparam logic [7:0]  OFF_ANALOG_SEL = 8'h20;
  localparam logic [7:0]  OFF_REACH_THR  = 8'h24;
  localparam logic [7:0]  OFF_THERM_LVL  = 8'h28;
  localparam logic [7:0]  OFF_RATED_CUR  = 8'h2C;
  localparam logic [7:0]  OFF_STATUS     = 8'h30;
  localparam logic [7:0]  OFF_THERM_TMR  = 8'h34;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h38;
  localparam logic [7:0]  OFF_IRQ_EN     = 8'h3C;
  localparam logic [7:0]  OFF_IRQ_CLR    = 8'h40;
  localparam logic [7:0]  OFF_STAGE      = 8'h80;
  // Status register field positions
  localparam int          ST_RELAY       = 0;
  localparam int          ST_DOUT        = 1;
  localparam int          ST_REACH       = 2;
  localparam int          ST_OVERLOAD    = 3;
  localparam int          ST_SERIAL      = 4;
  localparam int          ST_STAGE       = 8;
  // Interrupt bit positions
  localparam int          IRQ_RELAY      = 0;
  localparam int          IRQ_DOUT       = 1;
  localparam int          IRQ_REACH      = 2;
  localparam int          IRQ_OVERLOAD   = 3;
  localparam int          IRQ_STAGE      = 4;
  // Output function codes
  localparam logic [3:0]  FN_OFF         = 4'h0;
  localparam logic [3:0]  FN_FAULT       = 4'h1;
  localparam logic [3:0]  FN_RUN         = 4'h2;
  localparam logic [3:0]  FN_ZERO        = 4'h3;
  localparam logic [3:0]  FN_FWD         = 4'h4;
  localparam logic [3:0]  FN_REV         = 4'h5;
  localparam logic [3:0]  FN_ACCEL       = 4'h6;
  localparam logic [3:0]  FN_DECEL       = 4'h7;
  localparam logic [3:0]  FN_AGREE       = 4'h8;
  localparam logic [3:0]  FN_OVERLOAD    = 4'h9;
  localparam logic [3:0]  FN_REACH       = 4'hA;
  localparam logic [3:0]  FN_OUT_MAX     = 4'hA;
  // Input function codes
  localparam logic [3:0]  IN_STAGE1      = 4'h6;
  localparam logic [3:0]  IN_STAGE4      = 4'h9;
  localparam logic [3:0]  IN_MAX         = 4'hE;
  localparam logic [3:0]  IN_SERIAL      = 4'hF;
  // Reset values
  localparam logic [3:0]  RST_RELAY_SEL  = 4'h1;
  localparam logic [3:0]  RST_DOUT_SEL   = 4'hA;
  localparam logic [23:0] RST_DIN_SEL    = 24'h3A7621;
  localparam logic [7:0]  RST_ANALOG_SEL = 8'h00;
  localparam logic [15:0] RST_REACH_THR  = 16'h1770;
  localparam logic [7:0]  RST_THERM_LVL  = 8'h64;
  localparam logic [15:0] RST_RATED_CUR  = 16'h0064;
  // Frequency limits in 0.01 Hz units; percent scale factor
  localparam logic [15:0] REACH_MAX      = 16'h7530;
  localparam logic [15:0] REACH_HYST     = 16'h0032;
  localparam logic [7:0]  PCT_SCALE      = 8'h64;
  // Timing
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TICK_US        = 1000;
  localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
endpackage

// ### hdl/dsos_out_eval.sv
// Purpose: Maps one output function code onto the drive condition it selects
// Assumes: Condition vector indexed by function code, same clock domain
// Notes:   Output registered so it changes once per control cycle
`timescale 1ns/1ps
module dsos_out_eval (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_code,
  input  wire logic [10:0] i_cond,
  input  wire logic        i_allow,
  output logic             o_active
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_active <= 1'b0;
    end else if (!i_allow || i_code == dsos_pkg::FN_OFF
                 || i_code > dsos_pkg::FN_OUT_MAX) begin
      o_active <= 1'b0;
    end else begin
      o_active <= i_cond[i_code];
    end
  end
endmodule

// ### hdl/dsos_top.sv
// Function
// - The serial-link enable code is accepted only by the sixth input's selector and only that input activates it.
// - Four speed-select inputs form a binary stage number with weights 1,2,4,8; all off is master speed.
// - The digital output works only while the analog-output selection is zero.
// - Function code 0 holds the output inactive.
// - Code 1 closes the output while a failure is detected.
// - Code 2 closes the output while the drive is in standby or running.
// - Code 3 closes the output while stopped or at zero output frequency.
// - Code 4 asserts while forward run executes with frequency above zero.
// - Code 5 asserts while reverse run executes with frequency above zero.
// - Code 6 asserts while ramping up toward the target.
// - Code 7 asserts while ramping down toward the target.
// - Code 8 closes when output frequency equals the selected stage frequency.
// - Code 9 closes on overload above rated current times thermal percentage while the timer counts.
// - Code 10 turns on at the reach threshold (max 300.00 Hz) and off below threshold minus 0.5 Hz.
//
// Purpose: Selects drive status conditions onto relay and digital outputs
// Assumes: Drive state inputs are on i_clk; terminal inputs are asynchronous pins
// Notes:   Registers answered over Avalon-MM with one wait cycle
`timescale 1ns/1ps
module dsos_top #(
  parameter int TICK_CYC = dsos_pkg::TICK_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic [dsos_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [3:0]                i_avs_byteenable,
  input  wire logic [31:0]               i_avs_writedata,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  input  wire logic [dsos_pkg::NUM_DIN-1:0] i_din_pin,
  input  wire logic                      i_fault,
  input  wire logic                      i_standby,
  input  wire logic                      i_running,
  input  wire logic                      i_forward_run,
  input  wire logic                      i_reverse_run,
  input  wire logic                      i_accel,
  input  wire logic                      i_decel,
  input  wire logic [15:0]               i_out_freq,
  input  wire logic [15:0]               i_out_current,
  output logic                           o_relay_output,
  output logic                           o_dout,
  output logic                           o_analog_output_en,
  output logic [3:0]                     o_speed_stage,
  output logic                           o_serial_link_en,
  output logic                           o_irq
);
  logic [3:0]  din_sel [dsos_pkg::NUM_DIN];
  logic [3:0]  relay_function_sel;
  logic [3:0]  dout_function_sel;
  logic [7:0]  analog_out_sel;
  logic [15:0] reach_threshold;
  logic [7:0]  thermal_current_level;
  logic [15:0] motor_rated_current;
  logic [15:0] stage_freq [dsos_pkg::NUM_STAGE];
  logic [15:0] thermal_relay_timer;
  logic [dsos_pkg::NUM_IRQ-1:0] irq_status;
  logic [dsos_pkg::NUM_IRQ-1:0] irq_enable;
  logic [dsos_pkg::NUM_DIN-1:0] din_meta;
  logic [dsos_pkg::NUM_DIN-1:0] din_sync;
  logic        bus_ack;
  logic        reach_on;
  logic        overload;
  logic        overload_d;
  logic        reach_d;
  logic        relay_d;
  logic        dout_d;
  logic [3:0]  stage_d;
  logic [3:0]  next_stage;
  logic        next_serial;
  logic [10:0] cond;
  logic [23:0] load_scaled;
  logic [23:0] limit_scaled;
  logic [15:0] tick_cnt;
  logic        tick;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  addr;

  // Byte-lane merge, used by every configuration register; IRQ enable and clear use lane 0 only
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Legal input selector value for terminal index k
  function automatic logic din_code_ok(input int k, input logic [3:0] code);
    if (code == dsos_pkg::IN_SERIAL) begin
      return k == dsos_pkg::NUM_DIN - 1;
    end
    return code <= dsos_pkg::IN_MAX;
  endfunction

  assign addr     = i_avs_address;
  assign wr_go    = i_avs_write && bus_ack;
  assign rd_go    = i_avs_read && !bus_ack;
  // One wait cycle keeps read data registered
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
    end
  end

  // Terminal pins synchronised before use
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= i_din_pin;
      din_sync <= din_meta;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    logic [31:0] v;
    v = '0;
    if (i_rst) begin
      for (int k = 0; k < dsos_pkg::NUM_DIN; k++) begin
        din_sel[k] <= dsos_pkg::RST_DIN_SEL[4*k +: 4];
      end
      relay_function_sel    <= dsos_pkg::RST_RELAY_SEL;
      dout_function_sel     <= dsos_pkg::RST_DOUT_SEL;
      analog_out_sel        <= dsos_pkg::RST_ANALOG_SEL;
      reach_threshold       <= dsos_pkg::RST_REACH_THR;
      thermal_current_level <= dsos_pkg::RST_THERM_LVL;
      motor_rated_current   <= dsos_pkg::RST_RATED_CUR;
      for (int s = 0; s < dsos_pkg::NUM_STAGE; s++) begin
        stage_freq[s] <= '0;
      end
    end else if (wr_go) begin
      for (int k = 0; k < dsos_pkg::NUM_DIN; k++) begin
        if (addr == dsos_pkg::OFF_DIN_SEL + 8'(4*k)) begin
          v = merge_be({28'h0, din_sel[k]}, i_avs_writedata, i_avs_byteenable);
          if (v[31:4] == '0 && din_code_ok(k, v[3:0])) begin
            din_sel[k] <= v[3:0];
          end
        end
      end
      if (addr == dsos_pkg::OFF_RELAY_SEL) begin
        v = merge_be({28'h0, relay_function_sel}, i_avs_writedata, i_avs_byteenable);
        if (v[31:4] == '0 && v[3:0] <= dsos_pkg::FN_OUT_MAX) begin
          relay_function_sel <= v[3:0];
        end
      end
      if (addr == dsos_pkg::OFF_DOUT_SEL) begin
        v = merge_be({28'h0, dout_function_sel}, i_avs_writedata, i_avs_byteenable);
        if (v[31:4] == '0 && v[3:0] <= dsos_pkg::FN_OUT_MAX) begin
          dout_function_sel <= v[3:0];
        end
      end
      if (addr == dsos_pkg::OFF_ANALOG_SEL) begin
        v = merge_be({24'h0, analog_out_sel}, i_avs_writedata, i_avs_byteenable);
        analog_out_sel <= v[7:0];
      end
      if (addr == dsos_pkg::OFF_REACH_THR) begin
        v = merge_be({16'h0, reach_threshold}, i_avs_writedata, i_avs_byteenable);
        if (v[31:16] != '0 || v[15:0] > dsos_pkg::REACH_MAX) begin
          reach_threshold <= dsos_pkg::REACH_MAX;
        end else begin
          reach_threshold <= v[15:0];
        end
      end
      if (addr == dsos_pkg::OFF_THERM_LVL) begin
        v = merge_be({24'h0, thermal_current_level}, i_avs_writedata, i_avs_byteenable);
        thermal_current_level <= v[7:0];
      end
      if (addr == dsos_pkg::OFF_RATED_CUR) begin
        v = merge_be({16'h0, motor_rated_current}, i_avs_writedata, i_avs_byteenable);
        motor_rated_current <= v[15:0];
      end
      for (int s = 0; s < dsos_pkg::NUM_STAGE; s++) begin
        if (addr == dsos_pkg::OFF_STAGE + 8'(4*s)) begin
          v = merge_be({16'h0, stage_freq[s]}, i_avs_writedata, i_avs_byteenable);
          stage_freq[s] <= v[15:0];
        end
      end
    end
  end

  always_comb begin
    next_stage  = 4'h0;
    next_serial = 1'b0;
    for (int k = 0; k < dsos_pkg::NUM_DIN; k++) begin
      if (din_sync[k] && din_sel[k] >= dsos_pkg::IN_STAGE1
          && din_sel[k] <= dsos_pkg::IN_STAGE4) begin
        next_stage[2'(din_sel[k] - dsos_pkg::IN_STAGE1)] = 1'b1;
      end
    end
    if (din_sync[dsos_pkg::NUM_DIN-1]
        && din_sel[dsos_pkg::NUM_DIN-1] == dsos_pkg::IN_SERIAL) begin
      next_serial = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_speed_stage    <= 4'h0;
      o_serial_link_en <= 1'b0;
    end else begin
      o_speed_stage    <= next_stage;
      o_serial_link_en <= next_serial;
    end
  end

  assign load_scaled  = 24'(i_out_current) * 24'(dsos_pkg::PCT_SCALE);
  assign limit_scaled = 24'(motor_rated_current) * 24'(thermal_current_level);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      overload <= 1'b0;
    end else begin
      overload <= load_scaled > limit_scaled;
    end
  end

  // Millisecond tick for the thermal timer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !overload) begin
      thermal_relay_timer <= '0;
    end else if (tick && thermal_relay_timer != 16'hFFFF) begin
      thermal_relay_timer <= thermal_relay_timer + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reach_on <= 1'b0;
    end else if (i_out_freq >= reach_threshold) begin
      reach_on <= 1'b1;
    end else if (reach_threshold < dsos_pkg::REACH_HYST
                 || i_out_freq < reach_threshold - dsos_pkg::REACH_HYST) begin
      reach_on <= 1'b0;
    end
  end

  always_comb begin
    cond = '0;
    cond[dsos_pkg::FN_FAULT]    = i_fault;
    cond[dsos_pkg::FN_RUN]      = i_standby || i_running;
    cond[dsos_pkg::FN_ZERO]     = !i_running || i_out_freq == '0;
    cond[dsos_pkg::FN_FWD]      = i_forward_run && i_out_freq != '0;
    cond[dsos_pkg::FN_REV]      = i_reverse_run && i_out_freq != '0;
    cond[dsos_pkg::FN_ACCEL]    = i_accel;
    cond[dsos_pkg::FN_DECEL]    = i_decel;
    cond[dsos_pkg::FN_AGREE]    = i_out_freq == stage_freq[o_speed_stage];
    cond[dsos_pkg::FN_OVERLOAD] = overload;
    cond[dsos_pkg::FN_REACH]    = reach_on;
  end

  dsos_out_eval u_relay (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_code   (relay_function_sel),
    .i_cond   (cond),
    .i_allow  (1'b1),
    .o_active (o_relay_output)
  );

  dsos_out_eval u_dout (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_code   (dout_function_sel),
    .i_cond   (cond),
    .i_allow  (analog_out_sel == '0),
    .o_active (o_dout)
  );

  assign o_analog_output_en = analog_out_sel != '0;

  // Edge history for interrupt events
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      relay_d    <= 1'b0;
      dout_d     <= 1'b0;
      reach_d    <= 1'b0;
      overload_d <= 1'b0;
      stage_d    <= 4'h0;
    end else begin
      relay_d    <= o_relay_output;
      dout_d     <= o_dout;
      reach_d    <= reach_on;
      overload_d <= overload;
      stage_d    <= o_speed_stage;
    end
  end

  // Set beats clear in the same cycle
  always_ff @(posedge i_clk) begin
    logic [dsos_pkg::NUM_IRQ-1:0] set_v;
    set_v = '0;
    set_v[dsos_pkg::IRQ_RELAY]    = o_relay_output && !relay_d;
    set_v[dsos_pkg::IRQ_DOUT]     = o_dout && !dout_d;
    set_v[dsos_pkg::IRQ_REACH]    = reach_on && !reach_d;
    set_v[dsos_pkg::IRQ_OVERLOAD] = overload && !overload_d;
    set_v[dsos_pkg::IRQ_STAGE]    = o_speed_stage != stage_d;
    if (i_rst) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      if (wr_go && addr == dsos_pkg::OFF_IRQ_CLR && i_avs_byteenable[0]) begin
        irq_status <= (irq_status & ~i_avs_writedata[dsos_pkg::NUM_IRQ-1:0]) | set_v;
      end else begin
        irq_status <= irq_status | set_v;
      end
      if (wr_go && addr == dsos_pkg::OFF_IRQ_EN && i_avs_byteenable[0]) begin
        irq_enable <= i_avs_writedata[dsos_pkg::NUM_IRQ-1:0];
      end
    end
  end

  assign o_irq = |(irq_status & irq_enable);

  // Read data captured in the wait cycle; unmapped reads return zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (rd_go) begin
      o_avs_readdata <= '0;
      for (int k = 0; k < dsos_pkg::NUM_DIN; k++) begin
        if (addr == dsos_pkg::OFF_DIN_SEL + 8'(4*k)) begin
          o_avs_readdata <= {28'h0, din_sel[k]};
        end
      end
      for (int s = 0; s < dsos_pkg::NUM_STAGE; s++) begin
        if (addr == dsos_pkg::OFF_STAGE + 8'(4*s)) begin
          o_avs_readdata <= {16'h0, stage_freq[s]};
        end
      end
      unique case (addr)
        dsos_pkg::OFF_RELAY_SEL:  o_avs_readdata <= {28'h0, relay_function_sel};
        dsos_pkg::OFF_DOUT_SEL:   o_avs_readdata <= {28'h0, dout_function_sel};
        dsos_pkg::OFF_ANALOG_SEL: o_avs_readdata <= {24'h0, analog_out_sel};
        dsos_pkg::OFF_REACH_THR:  o_avs_readdata <= {16'h0, reach_threshold};
        dsos_pkg::OFF_THERM_LVL:  o_avs_readdata <= {24'h0, thermal_current_level};
        dsos_pkg::OFF_RATED_CUR:  o_avs_readdata <= {16'h0, motor_rated_current};
        dsos_pkg::OFF_STATUS: begin
          o_avs_readdata <= {20'h0, o_speed_stage, 3'h0, o_serial_link_en,
                             overload, reach_on, o_dout, o_relay_output};
        end
        dsos_pkg::OFF_THERM_TMR:  o_avs_readdata <= {16'h0, thermal_relay_timer};
        dsos_pkg::OFF_IRQ_STAT:   o_avs_readdata <= {27'h0, irq_status};
        dsos_pkg::OFF_IRQ_EN:     o_avs_readdata <= {27'h0, irq_enable};
        default: ;
      endcase
    end
  end
endmodule

// ### tb/dsos_equip.sv
// Purpose: Relay contact as seen by external control equipment
// Assumes: Contact level high means closed
// Notes:   Counts closures only; contact bounce is not modelled
`timescale 1ns/1ps
module dsos_equip (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_contact,
  output logic      [7:0] o_closures
);
  logic last;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last       <= 1'b0;
      o_closures <= 8'h00;
    end else begin
      last <= i_contact;
      if (i_contact && !last) begin
        o_closures <= o_closures + 8'h01;
      end
    end
  end
endmodule

// ### tb/dsos_top_properties.sv
// Purpose: Port-level properties of dsos_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Selector values are internal, so per-code checks live in the bench
`timescale 1ns/1ps
module dsos_top_props (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [5:0]  i_din_pin,
  input wire logic        o_dout,
  input wire logic        o_relay_output,
  input wire logic        o_analog_output_en,
  input wire logic [3:0]  o_speed_stage,
  input wire logic        o_serial_link_en,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  property p_rd_wait; $rose(i_avs_read) |-> s_one_wait; endproperty
  property p_wr_wait; $rose(i_avs_write) |-> s_one_wait; endproperty
  property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
  property p_rdata; !i_avs_read |=> $stable(o_avs_readdata); endproperty
  property p_rst_out;
    $fell(i_rst) |-> !(o_relay_output || o_dout || o_serial_link_en) && o_speed_stage == 4'h0;
  endproperty
  property p_aout; o_analog_output_en |=> !o_dout; endproperty
  property p_serial; o_serial_link_en |-> $past(i_din_pin[5], 3); endproperty
  property p_stage; o_speed_stage != 4'h0 |-> $past(i_din_pin[3:0], 3) != 4'h0; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_rdata: assert property (p_rdata) else $error("read data moved");
  a_rst_out: assert property (p_rst_out) else $error("output after reset");
  a_aout: assert property (p_aout) else $error("dout with analog on");
  a_serial: assert property (p_serial) else $error("serial without pin");
  a_stage: assert property (p_stage) else $error("stage without pins");
endmodule
bind dsos_top dsos_top_props i_props (.i_clk(i_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_readdata(o_avs_readdata), .i_din_pin(i_din_pin), .o_dout(o_dout),
  .o_relay_output(o_relay_output), .o_analog_output_en(o_analog_output_en),
  .o_speed_stage(o_speed_stage), .o_serial_link_en(o_serial_link_en), .o_irq(o_irq));

// ### tb/test_dsos_top.sv
// Purpose: Self-checking bench for dsos_top
// Assumes: One wait cycle per access, TICK_CYC cut to 4
// Notes:   Drive state poked directly; relay side is a counting model
`timescale 1ns/1ps
module test_dsos_top;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  adr   = 8'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wd    = 32'h0;
  logic [5:0]  pins  = 6'h00;
  logic [7:0]  drv   = 8'h00;
  logic [15:0] freq  = 16'h0000;
  logic [15:0] cur   = 16'h0000;
  logic [31:0] q;
  logic [31:0] rdat;
  logic        wreq, relay, dout, aen, ser, irq;
  logic [3:0]  stage;
  logic [7:0]  closes, n0;
  int          error_cnt = 0;
  int          check_count = 0;
  // Bit7 freq nonzero; 6..0 decel,accel,rev,fwd,run,standby,fault
  logic [7:0]  on_t [8]  = '{8'hFF, 8'h01, 8'h04, 8'h80, 8'h88, 8'h90, 8'hA0, 8'hC0};
  logic [7:0]  off_t [8] = '{8'h00, 8'h00, 8'h00, 8'h84, 8'h08, 8'h10, 8'h00, 8'h00};
  logic [15:0] f_t [5]   = '{16'h1770, 16'h173E, 16'h173D, 16'h176F, 16'h1770};
  logic [4:0]  e_t       = 5'b10011;
  dsos_top #(.TICK_CYC(4)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hF), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_din_pin(pins), .i_fault(drv[0]),
    .i_standby(drv[1]), .i_running(drv[2]), .i_forward_run(drv[3]), .i_reverse_run(drv[4]),
    .i_accel(drv[5]), .i_decel(drv[6]), .i_out_freq(freq), .i_out_current(cur),
    .o_relay_output(relay), .o_dout(dout), .o_analog_output_en(aen), .o_speed_stage(stage),
    .o_serial_link_en(ser), .o_irq(irq));
  dsos_equip i_equip (.i_clk(i_clk), .i_rst(i_rst), .i_contact(relay), .o_closures(closes));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    if (n >= 50) error_cnt++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic apply(input logic [7:0] b);
    drv  <= b;
    freq <= b[7] ? 16'h03E8 : 16'h0000;
  endtask
  initial begin
    #2_000_000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(8'h18, 32'h1);
    rdc(8'h1C, 32'hA);
    rdc(8'h14, 32'h3);
    rdc(8'h24, 32'h1770);
    wrt(8'h44, 32'hFFFF);
    rdc(8'h44, 32'h0);
    wrt(8'h00, 32'hF);
    rdc(8'h00, 32'h1);
    wrt(8'h14, 32'hF);
    rdc(8'h14, 32'hF);
    pins <= 6'h20;
    cyc(6);
    chk(ser, 1'b1);
    pins <= 6'h01;
    cyc(6);
    chk(ser, 1'b0);
    pins <= 6'h00;
    // Free the weights first so no two inputs share a stage code
    wrt(8'h08, 32'h8);
    wrt(8'h0C, 32'h9);
    wrt(8'h00, 32'h6);
    wrt(8'h04, 32'h7);
    for (int k = 0; k < 16; k++) begin
      pins <= k[5:0];
      cyc(5);
      chk(stage, k);
    end
    pins <= 6'h00;
    for (int c = 0; c < 8; c++) begin
      wrt(8'h18, c);
      wrt(8'h1C, c);
      apply(on_t[c]);
      cyc(4);
      chk({relay, dout}, {2{c != 0}});
      apply(off_t[c]);
      cyc(4);
      chk({relay, dout}, 2'b00);
    end
    // Fault code, so the analog gate is the only thing holding dout low
    wrt(8'h1C, 32'h1);
    wrt(8'h20, 32'h1);
    apply(8'h01);
    cyc(4);
    chk({aen, dout}, 2'b10);
    wrt(8'h20, 32'h0);
    cyc(4);
    chk({aen, dout}, 2'b01);
    wrt(8'h1C, 32'hA);
    drv <= 8'h00;
    for (int i = 0; i < 5; i++) begin
      freq <= f_t[i];
      cyc(4);
      chk(dout, e_t[i]);
    end
    wrt(8'h24, 32'hFFFF);
    rdc(8'h24, 32'h7530);
    wrt(8'h1C, 32'h0);
    wrt(8'h18, 32'h8);
    wrt(8'h80, 32'h3E8);
    freq <= 16'h03E8;
    cyc(6);
    chk(relay, 1'b1);
    freq <= 16'h03E9;
    cyc(4);
    chk(relay, 1'b0);
    wrt(8'hBC, 32'h7D0);
    pins <= 6'h0F;
    freq <= 16'h07D0;
    cyc(8);
    chk(relay, 1'b1);
    rdc(8'h30, 32'hF01);
    pins <= 6'h00;
    freq <= 16'h0000;
    wrt(8'h18, 32'h9);
    cur <= 16'h0065;
    cyc(4);
    chk(relay, 1'b1);
    // At least one tick falls inside the overload span
    bus(1'b0, 8'h34, 32'h0);
    chk(q != 32'h0, 1'b1);
    cur <= 16'h0064;
    cyc(4);
    chk(relay, 1'b0);
    rdc(8'h34, 32'h0);
    wrt(8'h18, 32'h1);
    wrt(8'h3C, 32'h1);
    wrt(8'h40, 32'h1F);
    cyc(1);
    chk(irq, 1'b0);
    n0 = closes;
    apply(8'h01);
    cyc(4);
    chk(irq, 1'b1);
    chk(closes, n0 + 8'h01);
    rdc(8'h38, 32'h1);
    wrt(8'h3C, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    wrt(8'h40, 32'h1);
    rdc(8'h38, 32'h0);
    final_report();
  end
endmodule
